/* File: shared/cisl_pkg.sv */
// constants, types and behaviour summary for the cpu interrupt source logic
// ----------------------------------------------------------------------------
// Behaviour
// - global cpu mask blocks all maskable requests; the software trap ignores it
// - priority by number, zero highest; lower number always served first
// - software trap is non-maskable and stacks pc itself, hardware stacks pc-1
// - break point hit makes the cpu execute the software trap
// - low level on external request pin latches a pending request
// - pll lock toggle sets change flag; enable gates the request
// - timer wrap to zero after modulo match sets wrap flag; enable gates
// - each timer channel capture or compare sets its flag; enable gates
// - sync rx byte into data register sets rx full flag; enable gates
// - sync tx byte into shift register sets tx empty flag; enable gates
// - mode fault: slave on select rise mid transfer, master on select low
// - sync byte arriving before previous read sets overflow; error enable gates
// - async character into tx shift register sets tx empty flag; enable gates
// - async both tx registers empty, no break or idle, sets done flag
// - async character into rx data register sets rx full flag; enable gates
// - after each instruction, mask clear, highest pending request is taken
// - taking an interrupt stacks, sets global mask, loads source vector
// ----------------------------------------------------------------------------
package cisl_pkg;

  // ----------------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------------
  localparam int         ADDR_W      = 5;
  localparam int         DATA_W      = 32;
  localparam logic [4:0] OFS_FLAGS   = 5'h00;
  localparam logic [4:0] OFS_ENABLE  = 5'h04;
  localparam logic [4:0] OFS_CTRL    = 5'h08;
  localparam logic [4:0] OFS_ACTIVE  = 5'h0c;
  localparam logic [4:0] OFS_VECTOR  = 5'h10;
  localparam int         NUM_REGS    = 5;

  localparam int         CTRL_GMASK    = 0;
  localparam int         CTRL_SYNC_MODE_FAULT_FLAG_CHK = 1;
  localparam logic       GMASK_RST     = 1'h1;
  localparam logic       SYNC_MODE_FAULT_FLAG_CHK_RST  = 1'h0;

  // ----------------------------------------------------------------------------
  // flag positions, shared by flags and enables
  // ----------------------------------------------------------------------------
  localparam int NUM_FLAGS   = 15;
  localparam int FLG_EXT     = 0;
  localparam int FLG_PLL     = 1;
  localparam int FLG_T1_CH0  = 2;
  localparam int FLG_T1_CH1  = 3;
  localparam int FLG_T1_WRAP = 4;
  localparam int FLG_T2_CH0  = 5;
  localparam int FLG_T2_CH1  = 6;
  localparam int FLG_T2_WRAP = 7;
  localparam int FLG_SRX     = 8;
  localparam int FLG_SOVF    = 9;
  localparam int FLG_SMODF   = 10;
  localparam int FLG_STX     = 11;
  localparam int FLG_ARX     = 12;
  localparam int FLG_ATX     = 13;
  localparam int FLG_ATC     = 14;
  localparam logic [14:0] ENABLE_RST = 15'h0000;

  // ----------------------------------------------------------------------------
  // request groups in priority order, index 0 highest
  // ----------------------------------------------------------------------------
  localparam int NUM_GROUPS = 12;
  localparam int GRP_IDX_W  = 4;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [11:0][15:0] GROUP_VECTOR = '{
    16'hffe2, 16'hffe4, 16'hffe8, 16'hffea, 16'hffec, 16'hffee,
    16'hfff0, 16'hfff2, 16'hfff4, 16'hfff6, 16'hfff8, 16'hfffa};

  typedef enum logic [1:0] {
    CISL_RUN   = 2'b01,
    CISL_ENTER = 2'b10
  } cisl_state_t;

endpackage

/* File: rtl/cisl_flag_bank.sv */
// sticky event flag bank, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module cisl_flag_bank #(
  parameter int W = 15
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // events and clears
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // flags
  output var  logic [W-1:0] flags
);

  if (W < 1 || W > 32) begin : g_bad_width
    $error("cisl_flag_bank: width out of range");
  end

  typedef struct packed {
    logic [W-1:0] flags;
  } cisl_bank_t;

  cisl_bank_t r;
  cisl_bank_t n;

  always_comb begin
    n = r;
    // an event in the clearing cycle must not be lost
    n.flags = (r.flags & ~clr) | set;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign flags = r.flags;

endmodule
`default_nettype wire

/* File: rtl/cisl_prio.sv */
// fixed priority pick, lowest index wins
`timescale 1ns/1ps
`default_nettype none
module cisl_prio #(
  parameter int N     = 12,
  parameter int IDX_W = 4
) (
  // requests
  input  wire logic [N-1:0]     req,
  // pick
  output var  logic             any,
  output var  logic [IDX_W-1:0] idx
);

  if (N < 1 || N > (1 << IDX_W)) begin : g_bad_size
    $error("cisl_prio: index too narrow for request count");
  end

  always_comb begin
    any = 1'b0;
    idx = '0;
    // walk downward so the lowest set index is left standing
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = IDX_W'(i);
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/cisl_top.sv */
// interrupt source gathering, masking and entry sequencing for the cpu core
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cisl_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  // external request pin
  input  wire logic        ext_irq_n,
  // clock generator unit
  input  wire logic        pll_locked,
  // timer unit one
  input  wire logic [1:0]  timer_one_ch_event,
  input  wire logic        timer_one_tick,
  input  wire logic        timer_one_at_modulo,
  // timer unit two
  input  wire logic [1:0]  timer_two_ch_event,
  input  wire logic        timer_two_tick,
  input  wire logic        timer_two_at_modulo,
  // synchronous serial port
  input  wire logic        sync_rx_byte,
  input  wire logic        sync_tx_load,
  input  wire logic        sync_master_mode,
  input  wire logic        sync_xfer_active,
  input  wire logic        sync_ss_n,
  // async serial port
  input  wire logic        async_tx_load,
  input  wire logic        async_rx_load,
  input  wire logic        async_tx_shift_empty,
  input  wire logic        async_tx_data_empty,
  input  wire logic        async_tx_break_idle,
  // break unit
  input  wire logic        break_match,
  // cpu core
  input  wire logic        cpu_instr_done,
  input  wire logic        cpu_trap_exec,
  input  wire logic        cpu_rti,
  output var  logic        cpu_force_trap,
  output var  logic        cpu_irq_req,
  output var  logic        cpu_take,
  output var  logic [15:0] cpu_vector,
  output var  logic        cpu_stack_pc_minus_one,
  // interrupt line
  output var  logic        irq
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                            ext_sync;
    logic [1:0]                            ss_sync;
    logic                                  ss_prev;
    logic                                  lock_prev;
    logic                                  lock_primed;
    logic                                  done_prev;
    logic [cisl_pkg::NUM_FLAGS-1:0]        enable;
    logic                                  gmask;
    logic                                  sync_mode_fault_flag_chk;
    cisl_pkg::cisl_state_t                 state;
    logic                                  force_trap;
    logic                                  take;
    logic [15:0]                           vector;
    logic                                  pc_minus_one;
    logic                                  irq_req;
    logic                                  irq;
    logic                                  waitreq;
    logic [31:0]                           rdata;
  } cisl_top_t;

  cisl_top_t r;
  cisl_top_t n;

  logic [cisl_pkg::NUM_FLAGS-1:0]   flags;
  logic [cisl_pkg::NUM_FLAGS-1:0]   flag_set;
  logic [cisl_pkg::NUM_FLAGS-1:0]   flag_clr;
  logic [cisl_pkg::NUM_FLAGS-1:0]   active;
  logic [cisl_pkg::NUM_GROUPS-1:0]  grp_req;
  logic [cisl_pkg::NUM_GROUPS-1:0]  grp_live;
  logic                             pr_any;
  logic [cisl_pkg::GRP_IDX_W-1:0]   pr_idx;
  logic                             ss_now;
  logic                             ss_rise;
  logic                             done_cond;
  logic                             bus_req;
  logic                             bus_accept;
  logic [cisl_pkg::NUM_REGS-1:0]    sel;
  logic [31:0]                      wmask;

  // ----------------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------------
  function automatic logic [cisl_pkg::NUM_REGS-1:0] reg_sel(input logic [4:0] a);
    logic [cisl_pkg::NUM_REGS-1:0] s;
    s = '0;
    unique case (a)
      cisl_pkg::OFS_FLAGS:  s[0] = 1'b1;
      cisl_pkg::OFS_ENABLE: s[1] = 1'b1;
      cisl_pkg::OFS_CTRL:   s[2] = 1'b1;
      cisl_pkg::OFS_ACTIVE: s[3] = 1'b1;
      cisl_pkg::OFS_VECTOR: s[4] = 1'b1;
      default:              s    = '0;
    endcase
    return s;
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // ----------------------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------------------
  assign ss_now    = r.ss_sync[1];
  assign ss_rise   = ss_now & ~r.ss_prev;
  assign done_cond = async_tx_shift_empty & async_tx_data_empty & ~async_tx_break_idle;

  // level source: stays set while the pin is held low, even across a clear
  assign flag_set[cisl_pkg::FLG_EXT]     = ~r.ext_sync[1];
  assign flag_set[cisl_pkg::FLG_PLL]     = r.lock_primed & (pll_locked ^ r.lock_prev);
  assign flag_set[cisl_pkg::FLG_T1_CH0]  = timer_one_ch_event[0];
  assign flag_set[cisl_pkg::FLG_T1_CH1]  = timer_one_ch_event[1];
  assign flag_set[cisl_pkg::FLG_T1_WRAP] = timer_one_tick & timer_one_at_modulo;
  assign flag_set[cisl_pkg::FLG_T2_CH0]  = timer_two_ch_event[0];
  assign flag_set[cisl_pkg::FLG_T2_CH1]  = timer_two_ch_event[1];
  assign flag_set[cisl_pkg::FLG_T2_WRAP] = timer_two_tick & timer_two_at_modulo;
  assign flag_set[cisl_pkg::FLG_SRX]     = sync_rx_byte;
  // unread byte is judged by the rx full flag still standing
  assign flag_set[cisl_pkg::FLG_SOVF]    = sync_rx_byte & flags[cisl_pkg::FLG_SRX];
  assign flag_set[cisl_pkg::FLG_SMODF]   = r.sync_mode_fault_flag_chk &
                                           (sync_master_mode ? ~ss_now
                                                             : (ss_rise & sync_xfer_active));
  assign flag_set[cisl_pkg::FLG_STX]     = sync_tx_load;
  assign flag_set[cisl_pkg::FLG_ARX]     = async_rx_load;
  assign flag_set[cisl_pkg::FLG_ATX]     = async_tx_load;
  assign flag_set[cisl_pkg::FLG_ATC]     = done_cond & ~r.done_prev;

  // ----------------------------------------------------------------------------
  // bus accept and flag clearing
  // ----------------------------------------------------------------------------
  assign bus_req    = avs_read | avs_write;
  assign bus_accept = bus_req & ~r.waitreq;
  assign sel        = reg_sel(avs_address);
  assign wmask      = lane_mask(avs_byteenable);
  assign flag_clr   = (bus_accept & avs_write & sel[0])
                      ? avs_writedata[cisl_pkg::NUM_FLAGS-1:0] & wmask[cisl_pkg::NUM_FLAGS-1:0]
                      : '0;

  cisl_flag_bank #(
    .W (cisl_pkg::NUM_FLAGS)
  ) u_flags (
    .clk   (clk),
    .reset (reset),
    .set   (flag_set),
    .clr   (flag_clr),
    .flags (flags)
  );

  // ----------------------------------------------------------------------------
  // gating and grouping
  // ----------------------------------------------------------------------------
  assign active = flags & r.enable;

  assign grp_req[0]  = active[cisl_pkg::FLG_EXT];
  assign grp_req[1]  = active[cisl_pkg::FLG_PLL];
  assign grp_req[2]  = active[cisl_pkg::FLG_T1_CH0];
  assign grp_req[3]  = active[cisl_pkg::FLG_T1_CH1];
  assign grp_req[4]  = active[cisl_pkg::FLG_T1_WRAP];
  assign grp_req[5]  = active[cisl_pkg::FLG_T2_CH0];
  assign grp_req[6]  = active[cisl_pkg::FLG_T2_CH1];
  assign grp_req[7]  = active[cisl_pkg::FLG_T2_WRAP];
  assign grp_req[8]  = active[cisl_pkg::FLG_SRX] | active[cisl_pkg::FLG_SOVF] |
                       active[cisl_pkg::FLG_SMODF];
  assign grp_req[9]  = active[cisl_pkg::FLG_STX];
  assign grp_req[10] = active[cisl_pkg::FLG_ARX];
  assign grp_req[11] = active[cisl_pkg::FLG_ATX] | active[cisl_pkg::FLG_ATC];

  assign grp_live = grp_req & {cisl_pkg::NUM_GROUPS{~r.gmask}};

  cisl_prio #(
    .N     (cisl_pkg::NUM_GROUPS),
    .IDX_W (cisl_pkg::GRP_IDX_W)
  ) u_prio (
    .req (grp_live),
    .any (pr_any),
    .idx (pr_idx)
  );

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    n = r;

    // two-flop synchronisers for the pins
    n.ext_sync    = {r.ext_sync[0], ext_irq_n};
    n.ss_sync     = {r.ss_sync[0], sync_ss_n};
    n.ss_prev     = ss_now;
    n.lock_prev   = pll_locked;
    // first cycle after reset only learns the lock level, no toggle
    n.lock_primed = 1'b1;
    n.done_prev   = done_cond;

    n.force_trap = break_match;
    n.take       = 1'b0;

    // bus: answer one cycle after the request is seen
    if (bus_req & r.waitreq) begin
      n.waitreq = 1'b0;
      n.rdata   = 32'h0000_0000;
      unique case (1'b1)
        sel[0]:  n.rdata[cisl_pkg::NUM_FLAGS-1:0]  = flags;
        sel[1]:  n.rdata[cisl_pkg::NUM_FLAGS-1:0]  = r.enable;
        sel[2]: begin
          n.rdata[cisl_pkg::CTRL_GMASK]    = r.gmask;
          n.rdata[cisl_pkg::CTRL_SYNC_MODE_FAULT_FLAG_CHK] = r.sync_mode_fault_flag_chk;
        end
        sel[3]:  n.rdata[cisl_pkg::NUM_GROUPS-1:0] = grp_req;
        sel[4]:  n.rdata[15:0]                     = r.vector;
        default: n.rdata                           = 32'h0000_0000;
      endcase
    end else if (bus_accept) begin
      n.waitreq = 1'b1;
      if (avs_write && sel[1]) begin
        n.enable = (r.enable & ~wmask[cisl_pkg::NUM_FLAGS-1:0]) |
                   (avs_writedata[cisl_pkg::NUM_FLAGS-1:0] & wmask[cisl_pkg::NUM_FLAGS-1:0]);
      end
      if (avs_write && sel[2] && avs_byteenable[0]) begin
        n.gmask    = avs_writedata[cisl_pkg::CTRL_GMASK];
        n.sync_mode_fault_flag_chk = avs_writedata[cisl_pkg::CTRL_SYNC_MODE_FAULT_FLAG_CHK];
      end
    end

    // return from interrupt clears the mask the entry had set
    if (cpu_rti) begin
      n.gmask = 1'b0;
    end

    // entry sequencing; entry setting the mask wins over any clear
    unique case (r.state)
      cisl_pkg::CISL_RUN: begin
        if (cpu_trap_exec) begin
          n.take         = 1'b1;
          n.vector       = cisl_pkg::VEC_TRAP;
          n.pc_minus_one = 1'b0;
          n.gmask        = 1'b1;
          n.state        = cisl_pkg::CISL_ENTER;
        end else if (cpu_instr_done && pr_any) begin
          n.take         = 1'b1;
          n.vector       = cisl_pkg::GROUP_VECTOR[pr_idx];
          n.pc_minus_one = 1'b1;
          n.gmask        = 1'b1;
          n.state        = cisl_pkg::CISL_ENTER;
        end
      end
      cisl_pkg::CISL_ENTER: begin
        // one dead cycle so the core sees the raised mask first
        n.state = cisl_pkg::CISL_RUN;
      end
      default: begin
        n.state = cisl_pkg::CISL_RUN;
      end
    endcase

    n.irq_req = pr_any;
    n.irq     = |grp_req;
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      r              <= '0;
      r.ext_sync     <= 2'h3;
      r.ss_sync      <= 2'h3;
      r.ss_prev      <= 1'h1;
      r.enable       <= cisl_pkg::ENABLE_RST;
      r.gmask        <= cisl_pkg::GMASK_RST;
      r.sync_mode_fault_flag_chk     <= cisl_pkg::SYNC_MODE_FAULT_FLAG_CHK_RST;
      r.state        <= cisl_pkg::CISL_RUN;
      r.vector       <= 16'h0000;
      r.waitreq      <= 1'h1;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign avs_readdata           = r.rdata;
  assign avs_waitrequest        = r.waitreq;
  assign cpu_force_trap         = r.force_trap;
  assign cpu_irq_req            = r.irq_req;
  assign cpu_take               = r.take;
  assign cpu_vector             = r.vector;
  assign cpu_stack_pc_minus_one = r.pc_minus_one;
  assign irq                    = r.irq;

endmodule
`default_nettype wire

/* File: verif/cisl_top_properties.sv */
// concurrent checks on the interrupt source logic ports
`timescale 1ns/1ps
`default_nettype none
module cisl_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  // break unit and cpu core
  input wire logic        break_match,
  input wire logic        cpu_instr_done,
  input wire logic        cpu_trap_exec,
  input wire logic        cpu_force_trap,
  input wire logic        cpu_irq_req,
  input wire logic        cpu_take,
  input wire logic [15:0] cpu_vector,
  input wire logic        cpu_stack_pc_minus_one,
  input wire logic        irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ------
  // entry sequencing
  // ------
  force_trap_a: assert property (break_match |=> cpu_force_trap)
    else $error("break match did not force the trap");
  trap_entry_a: assert property (cpu_trap_exec && !cpu_take |=>
    cpu_take && cpu_vector == 16'hfffc && !cpu_stack_pc_minus_one)
    else $error("trap entry wrong");
  hw_vector_a: assert property (cpu_take && cpu_stack_pc_minus_one |->
    cpu_vector inside {16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0,
    16'hffee, 16'hffec, 16'hffea, 16'hffe8, 16'hffe4, 16'hffe2})
    else $error("hardware entry vector wrong");
  mask_set_a: assert property (cpu_take |=> !cpu_irq_req)
    else $error("request survived entry");
  take_pulse_a: assert property (cpu_take |=> !cpu_take)
    else $error("entry pulse too long");
  take_cause_a: assert property (!cpu_trap_exec && !cpu_instr_done |=> !cpu_take)
    else $error("entry without instruction end");
  vec_hold_a: assert property (!cpu_take |-> $stable(cpu_vector))
    else $error("vector changed without entry");
  // ------
  // request gating
  // ------
  req_gate_a: assert property (cpu_irq_req |-> irq)
    else $error("cpu request without enabled flag");
  hw_needs_req_a: assert property (cpu_take && cpu_stack_pc_minus_one |-> irq)
    else $error("hardware entry without request");
  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");
  trap_cov: cover property (cpu_take && !cpu_stack_pc_minus_one);
  hw_cov: cover property (cpu_take && cpu_stack_pc_minus_one);
  masked_cov: cover property (irq && !cpu_irq_req);
endmodule
bind cisl_top cisl_checker i_chk (.clk, .reset, .avs_read, .avs_write, .avs_waitrequest,
  .break_match, .cpu_instr_done, .cpu_trap_exec, .cpu_force_trap, .cpu_irq_req,
  .cpu_take, .cpu_vector, .cpu_stack_pc_minus_one, .irq);
`default_nettype wire

/* File: verif/cisl_cpu_model.sv */
// behavioural cpu core: instruction ends, trap execution, returns
`timescale 1ns/1ps
`default_nettype none
module cisl_cpu_model (
  // clock and reset
  input wire logic  clk,
  input wire logic  reset,
  // from the block and the bench
  input wire logic  cpu_force_trap,
  input wire logic  ret_req,
  // to the block
  output var logic  cpu_instr_done,
  output var logic  cpu_trap_exec,
  output var logic  cpu_rti
);
  int gap;
  always @(posedge clk) begin
    if (reset) begin
      gap <= 0;
      cpu_instr_done <= 1'b0;
      cpu_trap_exec <= 1'b0;
      cpu_rti <= 1'b0;
    end else begin
      cpu_trap_exec <= cpu_force_trap;
      cpu_rti <= ret_req;
      // random gap: instructions end promptly or slowly
      cpu_instr_done <= (gap == 0);
      gap <= (gap == 0) ? $urandom_range(3, 0) : gap - 1;
    end
  end
endmodule
`default_nettype wire

/* File: verif/cpu_interrupt_source_logic_test.sv */
// self-checking bench for the interrupt source logic
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_source_logic_test;
  logic        clk, reset, avs_read, avs_write, avs_waitrequest, ext_irq_n, pll_locked;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rnd, e;
  logic [3:0]  avs_byteenable;
  logic [1:0]  timer_one_ch_event, timer_two_ch_event;
  logic        timer_one_tick, timer_one_at_modulo, timer_two_tick, timer_two_at_modulo;
  logic        sync_rx_byte, sync_tx_load, sync_master_mode, sync_xfer_active, sync_ss_n;
  logic        async_tx_load, async_rx_load, async_tx_shift_empty, async_tx_data_empty;
  logic        async_tx_break_idle, break_match, cpu_instr_done, cpu_trap_exec, cpu_rti;
  logic        cpu_force_trap, cpu_irq_req, cpu_take, cpu_stack_pc_minus_one, irq, ret_req;
  logic [15:0] cpu_vector;
  logic [31:0] exp_rd[$];
  logic [16:0] exp_tk[$];
  logic [16:0] tk;
  int          errors, checked;
  cisl_top i_dut (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .ext_irq_n, .pll_locked,
    .timer_one_ch_event, .timer_one_tick, .timer_one_at_modulo, .timer_two_ch_event,
    .timer_two_tick, .timer_two_at_modulo, .sync_rx_byte, .sync_tx_load, .sync_master_mode,
    .sync_xfer_active, .sync_ss_n, .async_tx_load, .async_rx_load, .async_tx_shift_empty,
    .async_tx_data_empty, .async_tx_break_idle, .break_match, .cpu_instr_done,
    .cpu_trap_exec, .cpu_rti, .cpu_force_trap, .cpu_irq_req, .cpu_take, .cpu_vector,
    .cpu_stack_pc_minus_one, .irq);
  cisl_cpu_model i_cpu (.clk, .reset, .cpu_force_trap, .ret_req, .cpu_instr_done,
    .cpu_trap_exec, .cpu_rti);
  // ------
  // reporting
  // ------
  task automatic end_of_test();
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  // ------
  // drivers
  // ------
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      errors++;
      end_of_test();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] x);
    exp_rd.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_take();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cpu_take !== 1'b1 && n < 100);
    if (n >= 100) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic ret();
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
  endtask
  task automatic fire(input int k);
    case (k)
      0: ext_irq_n <= 1'b0;
      1: pll_locked <= !pll_locked;
      2, 3: timer_one_ch_event <= 2'(1 << (k - 2));
      4: {timer_one_tick, timer_one_at_modulo} <= 2'h3;
      5, 6: timer_two_ch_event <= 2'(1 << (k - 5));
      7: {timer_two_tick, timer_two_at_modulo} <= 2'h3;
      8, 9: sync_rx_byte <= 1'b1;
      10: sync_ss_n <= 1'b0;
      11: sync_tx_load <= 1'b1;
      12: async_rx_load <= 1'b1;
      13: async_tx_load <= 1'b1;
      default: {async_tx_shift_empty, async_tx_data_empty} <= 2'h3;
    endcase
    // pins pass a two-flop sync, so hold them longer
    repeat ((k == 0 || k == 10) ? 4 : (k == 9) ? 2 : 1) @(posedge clk);
    {timer_one_ch_event, timer_two_ch_event, timer_one_tick, timer_two_tick} <= 6'h0;
    {timer_one_at_modulo, timer_two_at_modulo, sync_rx_byte, sync_tx_load} <= 4'h0;
    {async_rx_load, async_tx_load, async_tx_shift_empty, async_tx_data_empty} <= 4'h0;
    {ext_irq_n, sync_ss_n} <= 2'h3;
    repeat (4) @(posedge clk);
  endtask
  // ------
  // result watchers
  // ------
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk(avs_readdata, exp_rd.size() ? exp_rd.pop_front() : 32'hx);
    if (cpu_take === 1'b1) begin
      tk = exp_tk.size() ? exp_tk.pop_front() : 17'hx;
      chk({14'h0, cpu_irq_req, cpu_stack_pc_minus_one, cpu_vector},
        {14'h0, tk[16], tk});
    end
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ------
  // main sequence
  // ------
  initial begin
    {reset, ext_irq_n, sync_ss_n, sync_master_mode} <= 4'hf;
    {avs_read, avs_write, avs_address, avs_writedata, ret_req} <= '0;
    {pll_locked, timer_one_ch_event, timer_two_ch_event, timer_one_tick} <= '0;
    {timer_two_tick, timer_one_at_modulo, timer_two_at_modulo, sync_rx_byte} <= '0;
    {sync_tx_load, sync_xfer_active, async_tx_load, async_rx_load, break_match} <= '0;
    {async_tx_shift_empty, async_tx_data_empty, async_tx_break_idle} <= '0;
    avs_byteenable <= 4'hf;
    errors = 0;
    checked = 0;
    rnd = $urandom(50202);
    rnd = $urandom;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // a tick away from the modulo value is no wrap
    timer_one_tick <= 1'b1;
    @(posedge clk);
    timer_one_tick <= 1'b0;
    rd(cisl_pkg::OFS_FLAGS, 32'h0);
    rd(cisl_pkg::OFS_CTRL, 32'h1);
    rd(cisl_pkg::OFS_VECTOR, 32'h0);
    rd(5'h14, 32'h0);
    bus(1'b1, cisl_pkg::OFS_ENABLE, rnd);
    rd(cisl_pkg::OFS_ENABLE, rnd & 32'h7fff);
    bus(1'b1, cisl_pkg::OFS_ENABLE, 32'h7fff);
    bus(1'b1, cisl_pkg::OFS_CTRL, 32'h3);
    for (int k = 0; k < 15; k++) begin
      e = (k == 9) ? 32'h300 : 32'h1 << k;
      fire(k);
      rd(cisl_pkg::OFS_FLAGS, e);
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, cpu_irq_req}, 32'h0);
      bus(1'b1, cisl_pkg::OFS_FLAGS, e);
      rd(cisl_pkg::OFS_FLAGS, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    // two pending sources, lower number goes first
    fire(12);
    fire(2);
    rd(cisl_pkg::OFS_ACTIVE, 32'h404);
    exp_tk.push_back({1'b1, 16'hfff6});
    bus(1'b1, cisl_pkg::OFS_CTRL, 32'h0);
    wait_take();
    bus(1'b1, cisl_pkg::OFS_FLAGS, 32'h4);
    exp_tk.push_back({1'b1, 16'hffe4});
    ret();
    wait_take();
    rd(cisl_pkg::OFS_VECTOR, 32'hffe4);
    bus(1'b1, cisl_pkg::OFS_FLAGS, 32'h1000);
    // break while masked still enters through the trap
    exp_tk.push_back({1'b0, 16'hfffc});
    break_match <= 1'b1;
    @(posedge clk);
    break_match <= 1'b0;
    wait_take();
    ret();
    bus(1'b1, cisl_pkg::OFS_ENABLE, 32'h0);
    fire(1);
    chk({31'h0, irq}, 32'h0);
    exp_tk.push_back({1'b1, 16'hfff8});
    bus(1'b1, cisl_pkg::OFS_ENABLE, 32'h2);
    wait_take();
    bus(1'b1, cisl_pkg::OFS_FLAGS, 32'h2);
    chk(exp_tk.size(), 32'h0);
    chk(exp_rd.size(), 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
